/* File: common/mhc_pkg.sv */
// package: constants and types for the maintenance hours counter
`default_nettype none
package mhc_pkg;
  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned TICK_S = 60;
  localparam longint unsigned TICK_CYCLES_L = longint'(CLK_HZ) * longint'(TICK_S);
  localparam int TICK_W = 33;
  // --------------------------------------------------------------------
  // value ranges
  // --------------------------------------------------------------------
  localparam int HR_W = 17;
  localparam int MIN_W = 6;
  localparam int TOT_W = 23;
  localparam logic [HR_W-1:0] SI_HR_MAX = 17'h0270F;
  localparam logic [HR_W-1:0] RT_HR_MAX = 17'h1869F;
  localparam logic [MIN_W-1:0] MIN_MAX = 6'h3B;
  localparam logic [TOT_W-1:0] MIN_PER_HR = 23'h00003C;
  localparam logic [TOT_W-1:0] TOT_ZERO = 23'h000000;
  // --------------------------------------------------------------------
  // apb register map
  // --------------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SI = 8'h04;
  localparam logic [7:0] A_RT = 8'h08;
  localparam logic [7:0] A_TTG = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_IRQ_ST = 8'h14;
  localparam logic [7:0] A_IRQ_MSK = 8'h18;
  localparam logic [7:0] A_EXT_SI = 8'h1C;
  // ctrl bits
  localparam int C_CFG = 0;
  localparam int C_POLICY = 1;
  localparam int C_SRC = 2;
  localparam int C_W = 3;
  // status / irq bits
  localparam int S_DUE = 0;
  localparam int S_SAT = 1;
  localparam int S_IRST = 2;
  localparam int S_FRST = 3;
  localparam int S_MODE_LSB = 8;
  localparam int S_MON = 12;
  localparam int IRQ_W = 4;
  // time value fields: minutes low, hours from bit 8
  localparam int F_MIN_LSB = 0;
  localparam int F_HR_LSB = 8;
  typedef enum logic [1:0] {
    MHC_CFG = 2'b00,
    MHC_SEED = 2'b01,
    MHC_RUN = 2'b11
  } mhc_mode_t;
endpackage : mhc_pkg
`default_nettype wire

/* File: verilog/mhc_min_tick.sv */
// module: one-minute tick generator
`default_nettype none
module mhc_min_tick (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic run_i,
  output logic tick_o
);
  localparam logic [mhc_pkg::TICK_W-1:0] LAST =
    mhc_pkg::TICK_W'(mhc_pkg::TICK_CYCLES_L - 1);
  logic [mhc_pkg::TICK_W-1:0] cnt_q;
  // --------------------------------------------------------------------
  // divider
  // --------------------------------------------------------------------
  // minute base; paused by the clock enable and cleared while run_i is low
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else if (en_i) begin
      tick_o <= 1'b0;
      if (!run_i) begin
        cnt_q <= '0;
      end else if (cnt_q == LAST) begin
        cnt_q <= '0;
        tick_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule : mhc_min_tick
`default_nettype wire

/* File: verilog/mhc_hours_counter.sv */
// module: maintenance hours counter with apb register access
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// Implementation choices: the APB slave port and the address map.
`default_nettype none
module mhc_hours_counter (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic run_monitor_i,
  input wire logic interval_reset_i,
  input wire logic full_reset_i,
  input wire logic [15:0] ext_interval_hr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic due_flag_o,
  output logic irq_o
);
  localparam int HW = mhc_pkg::HR_W;
  localparam int MW = mhc_pkg::MIN_W;
  localparam int TW = mhc_pkg::TOT_W;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [TW-1:0] to_min(input logic [HW-1:0] hr, input logic [MW-1:0] mn);
    to_min = TW'(hr) * mhc_pkg::MIN_PER_HR + TW'(mn);
  endfunction : to_min

  function automatic logic [31:0] pack_time(input logic [TW-1:0] m);
    logic [TW-1:0] h;
    logic [TW-1:0] r;
    h = m / mhc_pkg::MIN_PER_HR;
    r = m % mhc_pkg::MIN_PER_HR;
    pack_time = '0;
    pack_time[mhc_pkg::F_MIN_LSB +: MW] = r[MW-1:0];
    pack_time[mhc_pkg::F_HR_LSB +: HW] = h[HW-1:0];
  endfunction : pack_time

  function automatic logic [TW-1:0] clamp_min(input logic [31:0] w, input logic [HW-1:0] hmax);
    logic [HW-1:0] h;
    logic [MW-1:0] m;
    h = w[mhc_pkg::F_HR_LSB +: HW];
    m = w[mhc_pkg::F_MIN_LSB +: MW];
    if (h > hmax) h = hmax;
    if (m > mhc_pkg::MIN_MAX) m = mhc_pkg::MIN_MAX;
    clamp_min = to_min(h, m);
  endfunction : clamp_min

  // one decode shared by every register write strobe
  function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] r);
    wr_hit = w && (a == r);
  endfunction : wr_hit

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  logic mon;
  logic irst_lvl;
  logic frst_lvl;
  logic irst_rise;
  logic frst_rise;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else if (clk_en_i) begin
      sync1_q <= {full_reset_i, interval_reset_i, run_monitor_i};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign mon = sync2_q[0];
  assign irst_lvl = sync2_q[1];
  assign frst_lvl = sync2_q[2];
  assign irst_rise = sync2_q[1] & ~prev_q[1];
  assign frst_rise = sync2_q[2] & ~prev_q[2];

  // --------------------------------------------------------------------
  // minute tick
  // --------------------------------------------------------------------
  logic tick;
  // a partial minute is dropped whenever the monitor falls
  mhc_min_tick u_tick (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .en_i(clk_en_i),
    .run_i(mon),
    .tick_o(tick)
  );

  // --------------------------------------------------------------------
  // apb access
  // --------------------------------------------------------------------
  logic acc;
  logic wr;
  logic mapped;
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i;
  assign mapped = (paddr_i <= mhc_pkg::A_EXT_SI) && (paddr_i[1:0] == 2'b00);
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;

  logic [mhc_pkg::C_W-1:0] ctrl_q;
  logic [mhc_pkg::IRQ_W-1:0] irq_st_q;
  logic [mhc_pkg::IRQ_W-1:0] irq_msk_q;
  logic [mhc_pkg::IRQ_W-1:0] ev;
  logic [mhc_pkg::IRQ_W-1:0] w1c;
  mhc_pkg::mhc_mode_t mode_q;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= '0;
      ctrl_q[mhc_pkg::C_CFG] <= 1'b1;
    end else if (clk_en_i && wr_hit(wr, paddr_i, mhc_pkg::A_CTRL)) begin
      ctrl_q <= pwdata_i[mhc_pkg::C_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_msk_q <= '0;
    end else if (clk_en_i && wr_hit(wr, paddr_i, mhc_pkg::A_IRQ_MSK)) begin
      irq_msk_q <= pwdata_i[mhc_pkg::IRQ_W-1:0];
    end
  end

  // set wins over a same-cycle write-one clear
  assign w1c = wr_hit(wr, paddr_i, mhc_pkg::A_IRQ_ST) ? pwdata_i[mhc_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_st_q <= '0;
    end else if (clk_en_i) begin
      irq_st_q <= (irq_st_q & ~w1c) | ev;
    end
  end
  assign irq_o = |(irq_st_q & irq_msk_q);

  // --------------------------------------------------------------------
  // counters
  // --------------------------------------------------------------------
  // real retention needs non-volatile backing; here si_q survives everything except
  // the async reset (a cold start); a full reset also zeroes rt_q and reloads ttg_q
  logic [TW-1:0] si_q;
  logic [TW-1:0] rt_q;
  logic [TW-1:0] ttg_q;
  logic [TW-1:0] si_new;
  logic [TW-1:0] rt_max;
  logic [TW-1:0] ext_min;
  logic [HW-1:0] ext_hr;
  logic si_wr;
  logic rt_wr;
  logic step;
  logic si_zero;
  logic si_change;
  logic rt_sat;
  logic irst_seen_q;
  logic due_q;

  assign rt_max = to_min(mhc_pkg::RT_HR_MAX, '0);
  assign rt_sat = rt_q >= rt_max;
  // referenced value carries hours only; out-of-range clamps to the top
  assign ext_hr = (HW'(ext_interval_hr_i) > mhc_pkg::SI_HR_MAX) ?
    mhc_pkg::SI_HR_MAX : HW'(ext_interval_hr_i);
  assign ext_min = to_min(ext_hr, '0);
  assign si_wr = wr_hit(wr, paddr_i, mhc_pkg::A_SI) && !ctrl_q[mhc_pkg::C_SRC];
  assign si_new = ctrl_q[mhc_pkg::C_SRC] ? ext_min :
    (si_wr ? clamp_min(pwdata_i, mhc_pkg::SI_HR_MAX) : si_q);
  assign si_change = si_new != si_q;
  assign rt_wr = wr_hit(wr, paddr_i, mhc_pkg::A_RT) && mode_q == mhc_pkg::MHC_CFG;
  assign step = tick && mon && mode_q == mhc_pkg::MHC_RUN;
  assign si_zero = (si_q == mhc_pkg::TOT_ZERO);

  // mode: cfg -> seed (one cycle) -> run
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= mhc_pkg::MHC_CFG;
    end else if (clk_en_i) begin
      case (mode_q)
        mhc_pkg::MHC_CFG: if (!ctrl_q[mhc_pkg::C_CFG]) mode_q <= mhc_pkg::MHC_SEED;
        mhc_pkg::MHC_SEED: mode_q <= mhc_pkg::MHC_RUN;
        mhc_pkg::MHC_RUN: if (ctrl_q[mhc_pkg::C_CFG]) mode_q <= mhc_pkg::MHC_CFG;
        default: mode_q <= mhc_pkg::MHC_CFG;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      si_q <= mhc_pkg::TOT_ZERO;
    end else if (clk_en_i) begin
      si_q <= si_new;
    end
  end

  // once set, only a cold start brings the remainder seed back
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irst_seen_q <= 1'b0;
    end else if (clk_en_i && irst_rise) begin
      irst_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rt_q <= mhc_pkg::TOT_ZERO;
    end else if (clk_en_i) begin
      if (frst_rise) begin
        rt_q <= mhc_pkg::TOT_ZERO;
      end else if (rt_wr) begin
        rt_q <= clamp_min(pwdata_i, mhc_pkg::RT_HR_MAX);
      end else if (step && !rt_sat) begin
        rt_q <= rt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ttg_q <= mhc_pkg::TOT_ZERO;
    end else if (clk_en_i) begin
      if (frst_rise || irst_rise) begin
        ttg_q <= si_new;
      end else if (mode_q == mhc_pkg::MHC_SEED && !irst_seen_q) begin
        if (si_zero) begin
          ttg_q <= mhc_pkg::TOT_ZERO;
        end else begin
          ttg_q <= si_q - (rt_q % si_q);
        end
      end else if (si_change) begin
        ttg_q <= si_new;
      end else if (step && ttg_q != mhc_pkg::TOT_ZERO) begin
        ttg_q <= ttg_q - 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // due flag
  // --------------------------------------------------------------------
  logic due_d;
  always_comb begin
    due_d = (ttg_q == mhc_pkg::TOT_ZERO);
    if (irst_lvl || frst_lvl) begin
      due_d = 1'b0;
    end else if (ctrl_q[mhc_pkg::C_POLICY] && !mon) begin
      due_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      due_q <= 1'b0;
    end else if (clk_en_i) begin
      due_q <= due_d;
    end
  end
  assign due_flag_o = due_q;

  logic sat_q;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sat_q <= 1'b0;
    end else if (clk_en_i) begin
      sat_q <= rt_sat;
    end
  end

  always_comb begin
    ev = '0;
    ev[mhc_pkg::S_DUE] = due_d & ~due_q;
    ev[mhc_pkg::S_SAT] = rt_sat & ~sat_q;
    ev[mhc_pkg::S_IRST] = irst_rise;
    ev[mhc_pkg::S_FRST] = frst_rise;
  end

  // --------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------
  // read data is a flop taken in setup: a value changed by that access shows next read
  logic [31:0] rd;
  always_comb begin
    rd = '0;
    case (paddr_i)
      mhc_pkg::A_CTRL: rd[mhc_pkg::C_W-1:0] = ctrl_q;
      mhc_pkg::A_SI: rd = pack_time(si_q);
      mhc_pkg::A_RT: rd = pack_time(rt_q);
      mhc_pkg::A_TTG: rd = pack_time(ttg_q);
      mhc_pkg::A_STAT: begin
        rd[mhc_pkg::S_DUE] = due_q;
        rd[mhc_pkg::S_SAT] = rt_sat;
        rd[mhc_pkg::S_IRST] = irst_lvl;
        rd[mhc_pkg::S_FRST] = frst_lvl;
        rd[mhc_pkg::S_MODE_LSB +: $bits(mhc_pkg::mhc_mode_t)] = mode_q;
        rd[mhc_pkg::S_MON] = mon;
      end
      mhc_pkg::A_IRQ_ST: rd[mhc_pkg::IRQ_W-1:0] = irq_st_q;
      mhc_pkg::A_IRQ_MSK: rd[mhc_pkg::IRQ_W-1:0] = irq_msk_q;
      mhc_pkg::A_EXT_SI: rd[15:0] = ext_interval_hr_i;
      default: rd = '0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= '0;
    end else if (clk_en_i && psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rd;
    end
  end
endmodule : mhc_hours_counter
`default_nettype wire

/* File: testbench/mhc_ctl_model.sv */
// model: control logic driving the monitor and the two reset inputs
`default_nettype none
module mhc_ctl_model (
  input wire logic core_clk_i,
  input wire logic mon_req_i,
  input wire logic irst_go_i,
  input wire logic frst_go_i,
  input wire logic [3:0] hold_i,
  output logic run_monitor_o,
  output logic interval_reset_o,
  output logic full_reset_o
);
  // ----------------------------------------------------------------
  // reset pulses held hold_i cycles after the last go cycle: a go held longer stretches them
  // ----------------------------------------------------------------
  logic [3:0] ir_q = 4'h0;
  logic [3:0] fr_q = 4'h0;
  always @(posedge core_clk_i) begin
    ir_q <= irst_go_i ? hold_i : ((ir_q != 4'h0) ? ir_q - 4'h1 : 4'h0);
    fr_q <= frst_go_i ? hold_i : ((fr_q != 4'h0) ? fr_q - 4'h1 : 4'h0);
  end
  assign run_monitor_o = mon_req_i;
  assign interval_reset_o = (ir_q != 4'h0);
  assign full_reset_o = (fr_q != 4'h0);
endmodule : mhc_ctl_model
`default_nettype wire

/* File: testbench/mhc_hours_counter_chk.sv */
// checker: port-level assertions for the hours counter
`default_nettype none
module mhc_hours_counter_chk (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic run_monitor_i,
  input wire logic interval_reset_i,
  input wire logic full_reset_i,
  input wire logic [15:0] ext_interval_hr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic due_flag_o,
  input wire logic irq_o
);
  // ----------------------------------------------------------------
  // shadow of policy and mask, taken from apb writes
  // ----------------------------------------------------------------
  logic pol_q;
  logic [3:0] msk_q;
  logic wr_acc;
  logic bad_a;
  assign wr_acc = psel_i & penable_i & pwrite_i & clk_en_i;
  assign bad_a = (paddr_i > 8'h1C) | (paddr_i[1:0] != 2'h0);
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pol_q <= 1'b0;
      msk_q <= 4'h0;
    end else if (wr_acc) begin
      if (paddr_i == mhc_pkg::A_CTRL) pol_q <= pwdata_i[mhc_pkg::C_POLICY];
      if (paddr_i == mhc_pkg::A_IRQ_MSK) msk_q <= pwdata_i[3:0];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // margin of five covers the two sync stages and the due register
  chk_pready_high: assert property (pready_o) else $error("pready low");
  chk_bad_addr_err: assert property (psel_i && penable_i && bad_a |-> pslverr_o)
    else $error("no error on bad address");
  chk_good_addr_ok: assert property (psel_i && penable_i && !bad_a |-> !pslverr_o)
    else $error("error on good address");
  chk_bad_rd_zero: assert property (psel_i && !penable_i && !pwrite_i && bad_a ##1 penable_i
    |-> prdata_o == 32'h0) else $error("bad read not zero");
  chk_irst_due_low: assert property ((interval_reset_i && clk_en_i)[*5] |=> !due_flag_o)
    else $error("due high in interval reset");
  chk_frst_due_low: assert property ((full_reset_i && clk_en_i)[*5] |=> !due_flag_o)
    else $error("due high in full reset");
  chk_idle_due_low: assert property ((pol_q && !run_monitor_i && clk_en_i)[*5] |=> !due_flag_o)
    else $error("due high while idle");
  chk_mask_quiet: assert property (msk_q == 4'h0 |-> !irq_o) else $error("irq while masked");
  cov_irst: cover property (interval_reset_i[*5]);
  cov_idle: cover property (pol_q && !run_monitor_i);
  cov_irq: cover property (irq_o);
endmodule : mhc_hours_counter_chk
bind mhc_hours_counter mhc_hours_counter_chk u_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
  .run_monitor_i(run_monitor_i), .interval_reset_i(interval_reset_i),
  .full_reset_i(full_reset_i), .ext_interval_hr_i(ext_interval_hr_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .due_flag_o(due_flag_o), .irq_o(irq_o)
);
`default_nettype wire

/* File: testbench/mhc_hours_counter_tb_top.sv */
// testbench: directed scenarios for the hours counter
`default_nettype none
module mhc_hours_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic mon = 1'b1;
  logic igo = 1'b0;
  logic fgo = 1'b0;
  logic [3:0] hold = 4'h8;
  logic [15:0] ext_hr = 16'h0000;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic en = 1'b1;
  logic [31:0] prd;
  logic prdy, perr, due, irq, runm, irst, frst;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int n_tests = 0;
  initial forever #4 core_clk_i = ~core_clk_i;
  mhc_ctl_model u_ctl (.core_clk_i(core_clk_i), .mon_req_i(mon), .irst_go_i(igo),
    .frst_go_i(fgo), .hold_i(hold), .run_monitor_o(runm), .interval_reset_o(irst),
    .full_reset_o(frst));
  // tick span is 7.5e9 cycles: counting itself is out of reach here
  mhc_hours_counter dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .clk_en_i(en),
    .run_monitor_i(runm), .interval_reset_i(irst), .full_reset_i(frst),
    .ext_interval_hr_i(ext_hr), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .due_flag_o(due), .irq_o(irq));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task end_of_test();
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge core_clk_i);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk_i);
      i++;
    end while (prdy !== 1'b1 && i < 50);
    if (i >= 50) begin
      error_cnt++;
      end_of_test();
    end
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task pulse(input logic full, input logic [3:0] len);
    hold <= len;
    if (full) fgo <= 1'b1;
    else igo <= 1'b1;
    @(posedge core_clk_i);
    fgo <= 1'b0;
    igo <= 1'b0;
  endtask : pulse
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_map();
    apb(1'b0, mhc_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, mhc_pkg::A_IRQ_MSK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h22, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("t_map done");
  endtask : t_map
  task t_seed();
    apb(1'b1, mhc_pkg::A_SI, 32'h00FFFFFF);
    apb(1'b0, mhc_pkg::A_SI, 32'h0);
    chk(rd, 32'h00270F3B);
    apb(1'b1, mhc_pkg::A_SI, 32'h00001E00);
    apb(1'b1, mhc_pkg::A_RT, 32'h00006400);
    apb(1'b1, mhc_pkg::A_CTRL, 32'h0);
    repeat (8) @(posedge core_clk_i);
    apb(1'b0, mhc_pkg::A_TTG, 32'h0);
    chk(rd, 32'h00001400);
    apb(1'b0, mhc_pkg::A_RT, 32'h0);
    chk(rd, 32'h00006400);
    apb(1'b1, mhc_pkg::A_RT, 32'h00000100);
    apb(1'b0, mhc_pkg::A_RT, 32'h0);
    chk(rd, 32'h00006400);
    pulse(1'b0, 4'h4);
    repeat (8) @(posedge core_clk_i);
    apb(1'b0, mhc_pkg::A_TTG, 32'h0);
    chk(rd, 32'h00001E00);
    apb(1'b1, mhc_pkg::A_SI, 32'h00000A00);
    apb(1'b0, mhc_pkg::A_TTG, 32'h0);
    chk(rd, 32'h00000A00);
    $display("t_seed done");
  endtask : t_seed
  task t_resets();
    apb(1'b1, mhc_pkg::A_SI, 32'h0);
    repeat (8) @(posedge core_clk_i);
    chk({31'h0, due}, 32'h1);
    pulse(1'b0, 4'h8);
    repeat (6) @(posedge core_clk_i);
    chk({31'h0, due}, 32'h0);
    repeat (10) @(posedge core_clk_i);
    chk({31'h0, due}, 32'h1);
    apb(1'b0, mhc_pkg::A_RT, 32'h0);
    chk(rd, 32'h00006400);
    apb(1'b0, mhc_pkg::A_IRQ_ST, 32'h0);
    chk(rd & 32'hF, 32'h5);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, mhc_pkg::A_IRQ_MSK, 32'h4);
    // mask lands at the access edge: look one edge later
    @(posedge core_clk_i);
    chk({31'h0, irq}, 32'h1);
    pulse(1'b1, 4'h6);
    repeat (16) @(posedge core_clk_i);
    apb(1'b0, mhc_pkg::A_RT, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, due}, 32'h1);
    apb(1'b1, mhc_pkg::A_IRQ_ST, 32'hF);
    apb(1'b0, mhc_pkg::A_IRQ_ST, 32'h0);
    chk(rd & 32'hE, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("t_resets done");
  endtask : t_resets
  task t_policy();
    mon <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    chk({31'h0, due}, 32'h1);
    apb(1'b1, mhc_pkg::A_CTRL, 32'h2);
    repeat (8) @(posedge core_clk_i);
    chk({31'h0, due}, 32'h0);
    mon <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    chk({31'h0, due}, 32'h1);
    apb(1'b1, mhc_pkg::A_CTRL, 32'h0);
    $display("t_policy done");
  endtask : t_policy
  task t_ext();
    ext_hr <= 16'h0030;
    apb(1'b1, mhc_pkg::A_CTRL, 32'h4);
    repeat (8) @(posedge core_clk_i);
    apb(1'b0, mhc_pkg::A_TTG, 32'h0);
    chk(rd, 32'h00003000);
    apb(1'b1, mhc_pkg::A_SI, 32'h00000100);
    apb(1'b0, mhc_pkg::A_TTG, 32'h0);
    chk(rd, 32'h00003000);
    $display("t_ext done");
  endtask : t_ext
  task t_sat();
    apb(1'b1, mhc_pkg::A_CTRL, 32'h1);
    apb(1'b1, mhc_pkg::A_RT, 32'h01869E3B);
    apb(1'b0, mhc_pkg::A_STAT, 32'h0);
    chk(rd, 32'h00001000);
    apb(1'b1, mhc_pkg::A_RT, 32'h01869F00);
    apb(1'b0, mhc_pkg::A_STAT, 32'h0);
    chk(rd, 32'h00001002);
    apb(1'b0, mhc_pkg::A_IRQ_ST, 32'h0);
    chk(rd & 32'h2, 32'h2);
    apb(1'b1, mhc_pkg::A_RT, 32'h01FFFFFF);
    apb(1'b0, mhc_pkg::A_RT, 32'h0);
    chk(rd, 32'h01869F3B);
    // clock enable low: the write must be lost
    en <= 1'b0;
    apb(1'b1, mhc_pkg::A_SI, 32'h00000500);
    en <= 1'b1;
    apb(1'b0, mhc_pkg::A_SI, 32'h0);
    chk(rd, 32'h00003000);
    apb(1'b1, mhc_pkg::A_SI, 32'h00000500);
    apb(1'b0, mhc_pkg::A_TTG, 32'h0);
    chk(rd, 32'h00000500);
    $display("t_sat done");
  endtask : t_sat
  initial begin
    repeat (16) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    t_map();
    t_seed();
    t_resets();
    t_policy();
    t_ext();
    t_sat();
    end_of_test();
  end
endmodule : mhc_hours_counter_tb_top
`default_nettype wire
